// ---- rtl/ioexp_cfg.svh ----
`ifndef IOEXP_CFG_SVH
`define IOEXP_CFG_SVH

// ****************************************************************
// timing
// ****************************************************************
`define IOEXP_CLK_PERIOD_NS   10
`define IOEXP_DEBOUNCE_NS     3170000
`define IOEXP_DEBOUNCE_CYC    ((`IOEXP_DEBOUNCE_NS + `IOEXP_CLK_PERIOD_NS - 1) / `IOEXP_CLK_PERIOD_NS)

// ****************************************************************
// bus address and port-mode codes
// ****************************************************************
`define IOEXP_ADDR_MAX        4'hE
`define IOEXP_MODE_OUT_LOW    4'h1
`define IOEXP_MODE_OUT_HIGH   4'h2
`define IOEXP_MODE_IN_DEB     4'h3
`define IOEXP_MODE_IN_IRQ     4'h4
`define IOEXP_MODE_IN_DEB_IRQ 4'h5
`define IOEXP_MODE_NO_CHANGE  4'h9

// ****************************************************************
// command codes
// ****************************************************************
`define IOEXP_CMD_CNT_LO      7'h01
`define IOEXP_CMD_CNT_HI      7'h10
`define IOEXP_CMD_PER_LO      7'h11
`define IOEXP_CMD_PER_HI      7'h20
`define IOEXP_CMD_HIGH_LO     7'h21
`define IOEXP_CMD_HIGH_HI     7'h30
`define IOEXP_CMD_LEVELS      7'h31
`define IOEXP_CMD_READ_HI     7'h45
`define IOEXP_CMD_SEND_LO     7'h46
`define IOEXP_CMD_SEND_HI     7'h55
`define IOEXP_CMD_READ_X1     7'h5B
`define IOEXP_CMD_READ_X2     7'h5C
`define IOEXP_CMD_SEND2_LO    7'h5D
`define IOEXP_CMD_SEND2_HI    7'h62
`define IOEXP_CMD_READ_X3     7'h63

// ****************************************************************
// reset values
// ****************************************************************
`define IOEXP_RST_DATA        32'h0000_0000
`define IOEXP_RST_PINS        16'h0000

`endif

// ---- rtl/ioexp_pkg.sv ----
package ioexp_pkg;

    typedef struct packed {
        logic        valid;
        logic [3:0]  addr;
        logic [6:0]  code;
        logic [15:0] mode_16_13;
        logic [15:0] mode_12_9;
        logic [15:0] mode_8_5;
        logic [15:0] mode_4_1;
        logic [31:0] wdata;
    } ioexp_cmd_t;

    typedef struct packed {
        logic        valid;
        logic        ok;
        logic [31:0] rdata;
    } ioexp_rsp_t;

    typedef struct packed {
        logic out_en;
        logic out_val;
        logic deb_en;
        logic irq_en;
    } ioexp_cfg_t;

endpackage

// ---- rtl/ioexp_port.sv ----
`timescale 1ns/1ns
`include "ioexp_cfg.svh"

module ioexp_port #(
    parameter int DEB_CYC = `IOEXP_DEBOUNCE_CYC,
    parameter int CW      = 32
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          pin_in,
    input  wire logic          deb_en,
    input  wire logic          cnt_clr,
    output logic               level_r,
    output logic               change_r,
    output logic [CW-1:0]      count_r,
    output logic [CW-1:0]      period_r,
    output logic [CW-1:0]      high_r
);
    localparam int DW = $clog2(DEB_CYC + 1);

    logic          s1_r;
    logic          s2_r;
    logic [DW-1:0] deb_cnt_r;
    logic          filt_r;
    logic          src;
    logic [CW-1:0] per_cnt_r;
    logic [CW-1:0] hi_cnt_r;
    logic          rise;
    logic          fall;

    // ****************************************************************
    // synchroniser and debounce
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
        end

    // contact must hold steady for the whole window before it is believed
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            deb_cnt_r <= '0;
            filt_r    <= 1'b0;
        end
        else if (s2_r == filt_r)
            deb_cnt_r <= '0;
        else if (deb_cnt_r == DW'(DEB_CYC - 1))
        begin
            deb_cnt_r <= '0;
            filt_r    <= s2_r;
        end
        else
            deb_cnt_r <= deb_cnt_r + 1'b1;

    assign src  = deb_en ? filt_r : s2_r;
    assign rise = src & ~level_r;
    assign fall = ~src & level_r;

    // ****************************************************************
    // level, change, count
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            level_r  <= 1'b0;
            change_r <= 1'b0;
        end
        else
        begin
            level_r  <= src;
            change_r <= rise | fall;
        end

    // an edge in the clearing cycle is kept
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            count_r <= '0;
        else if (cnt_clr)
            count_r <= rise ? CW'(1) : '0;
        else if (rise)
            count_r <= count_r + 1'b1;

    // ****************************************************************
    // period and high time, in clock cycles, rising edge to rising edge
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            per_cnt_r <= '0;
            hi_cnt_r  <= '0;
            period_r  <= '0;
            high_r    <= '0;
        end
        else if (rise)
        begin
            period_r  <= per_cnt_r + 1'b1;
            high_r    <= hi_cnt_r;
            per_cnt_r <= '0;
            hi_cnt_r  <= '0;
        end
        else
        begin
            if (~&per_cnt_r)
                per_cnt_r <= per_cnt_r + 1'b1;
            if (level_r && ~&hi_cnt_r)
                hi_cnt_r <= hi_cnt_r + 1'b1;
        end

endmodule

// ---- rtl/ioexp_top.sv ----
`timescale 1ns/1ns
`include "ioexp_cfg.svh"

// Behaviour
// - each port individually input or output
// - input gives level and counts pulses
// - input measures frequency and duty cycle
// - irq when enabled input changes state
// - modes arrive as four four-port groups
// - codes 1 low, 2 high, 3 debounced
// - 4 irq raw, 5 irq debounced, 9 keep
// - answer only own address, 0 to 14
// - codes 1-69, 91, 92, 99 return values
module ioexp_top #(
    parameter int NPORT   = 16,
    parameter int DEB_CYC = `IOEXP_DEBOUNCE_CYC
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic [3:0]          dev_addr,
    input  wire ioexp_pkg::ioexp_cmd_t cmd,
    output ioexp_pkg::ioexp_rsp_t    rsp_r,
    input  wire logic [NPORT-1:0]    pin_in,
    output logic [NPORT-1:0]         pin_out_r,
    output logic [NPORT-1:0]         pin_oe_r,
    output logic                     irq_r
);
    logic                  addr_r;
    logic                  hit;
    logic [63:0]           mode_all;
    ioexp_pkg::ioexp_cfg_t cfg_r [NPORT];
    logic [NPORT-1:0]      level;
    logic [NPORT-1:0]      change;
    logic [NPORT-1:0]      cnt_clr;
    logic [31:0]           count [NPORT];
    logic [31:0]           period [NPORT];
    logic [31:0]           high [NPORT];
    logic                  is_read;
    logic                  is_send;
    logic [3:0]            sel;
    logic                  is_clr;
    logic [3:0]            clr_sel;
    logic [31:0]           rdata;
    logic                  irq_set;
    logic                  irq_clr;

    // ****************************************************************
    // addressing
    // ****************************************************************
    // address 15 is never answered, so a stray strap cannot respond
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            addr_r <= 1'b0;
        else
            addr_r <= (dev_addr <= `IOEXP_ADDR_MAX);

    assign hit = cmd.valid && addr_r && (cmd.addr == dev_addr);

    // group 16-13 sits in the top nibbles, 4-1 in the bottom
    assign mode_all = {cmd.mode_16_13, cmd.mode_12_9, cmd.mode_8_5, cmd.mode_4_1};

    // ****************************************************************
    // per-port configuration, pins and measurement
    // ****************************************************************
    generate
        for (genvar i = 0; i < NPORT; i++)
        begin : g_port
            logic [3:0] mcode;
            assign mcode = mode_all[4*i +: 4];

            always_ff @(posedge clk or negedge rst_b)
                if (!rst_b)
                    cfg_r[i] <= '0;
                else if (hit)
                begin
                    case (mcode)
                        `IOEXP_MODE_OUT_LOW:
                        begin
                            cfg_r[i].out_en  <= 1'b1;
                            cfg_r[i].out_val <= 1'b0;
                            cfg_r[i].deb_en  <= 1'b0;
                            cfg_r[i].irq_en  <= 1'b0;
                        end
                        `IOEXP_MODE_OUT_HIGH:
                        begin
                            cfg_r[i].out_en  <= 1'b1;
                            cfg_r[i].out_val <= 1'b1;
                            cfg_r[i].deb_en  <= 1'b0;
                            cfg_r[i].irq_en  <= 1'b0;
                        end
                        `IOEXP_MODE_IN_DEB:
                        begin
                            cfg_r[i].out_en  <= 1'b0;
                            cfg_r[i].out_val <= 1'b0;
                            cfg_r[i].deb_en  <= 1'b1;
                            cfg_r[i].irq_en  <= 1'b0;
                        end
                        `IOEXP_MODE_IN_IRQ:
                        begin
                            cfg_r[i].out_en  <= 1'b0;
                            cfg_r[i].out_val <= 1'b0;
                            cfg_r[i].deb_en  <= 1'b0;
                            cfg_r[i].irq_en  <= 1'b1;
                        end
                        `IOEXP_MODE_IN_DEB_IRQ:
                        begin
                            cfg_r[i].out_en  <= 1'b0;
                            cfg_r[i].out_val <= 1'b0;
                            cfg_r[i].deb_en  <= 1'b1;
                            cfg_r[i].irq_en  <= 1'b1;
                        end
                        `IOEXP_MODE_NO_CHANGE:  cfg_r[i] <= cfg_r[i];
                        // 6..8 and any other code keep the port as it is
                        default:                cfg_r[i] <= cfg_r[i];
                    endcase
                end

            // pins follow the stored mode one cycle later, straight from flops
            always_ff @(posedge clk or negedge rst_b)
                if (!rst_b)
                begin
                    pin_oe_r[i]  <= 1'b0;
                    pin_out_r[i] <= 1'b0;
                end
                else
                begin
                    pin_oe_r[i]  <= cfg_r[i].out_en;
                    pin_out_r[i] <= cfg_r[i].out_en & cfg_r[i].out_val;
                end

            ioexp_port #(
                .DEB_CYC (DEB_CYC),
                .CW      (32)
            ) u_port (
                .clk      (clk),
                .rst_b    (rst_b),
                .pin_in   (pin_in[i]),
                .deb_en   (cfg_r[i].deb_en),
                .cnt_clr  (cnt_clr[i]),
                .level_r  (level[i]),
                .change_r (change[i]),
                .count_r  (count[i]),
                .period_r (period[i]),
                .high_r   (high[i])
            );

            assign cnt_clr[i] = hit && is_clr && (clr_sel == 4'(i));
        end
    endgenerate

    // ****************************************************************
    // command decode
    // ****************************************************************
    assign is_read = ((cmd.code >= `IOEXP_CMD_CNT_LO) && (cmd.code <= `IOEXP_CMD_READ_HI))
                   || (cmd.code == `IOEXP_CMD_READ_X1) || (cmd.code == `IOEXP_CMD_READ_X2)
                   || (cmd.code == `IOEXP_CMD_READ_X3);
    assign is_send = ((cmd.code >= `IOEXP_CMD_SEND_LO) && (cmd.code <= `IOEXP_CMD_SEND_HI))
                   || ((cmd.code >= `IOEXP_CMD_SEND2_LO) && (cmd.code <= `IOEXP_CMD_SEND2_HI));
    // low four bits of the code offset pick the port within each bank
    assign sel = 4'(cmd.code - 7'h01);

    // ****************************************************************
    // count clear: only the first send bank names a port
    // ****************************************************************
    // the second send bank is accepted but must leave every count alone
    assign is_clr  = (cmd.code >= `IOEXP_CMD_SEND_LO)
                   && (cmd.code <= `IOEXP_CMD_SEND_HI);
    assign clr_sel = 4'(cmd.code - `IOEXP_CMD_SEND_LO);

    always_comb
    begin
        rdata = `IOEXP_RST_DATA;
        if (cmd.code <= `IOEXP_CMD_CNT_HI)
            rdata = count[sel];
        else if (cmd.code <= `IOEXP_CMD_PER_HI)
            rdata = period[sel];
        else if (cmd.code <= `IOEXP_CMD_HIGH_HI)
            rdata = high[sel];
        else if (cmd.code == `IOEXP_CMD_LEVELS)
            rdata = 32'(level);
    end

    // ****************************************************************
    // answer: one cycle after an addressed command
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            rsp_r <= '0;
        else
        begin
            rsp_r.valid <= hit;
            rsp_r.ok    <= hit && (is_read || is_send);
            // sends and refused codes answer zero so no stale count leaks out
            rsp_r.rdata <= (hit && is_read) ? rdata : `IOEXP_RST_DATA;
        end

    // ****************************************************************
    // change interrupt, cleared by the level read
    // ****************************************************************
    // a change only interrupts while the port is an enabled input
    always_comb
    begin
        irq_set = 1'b0;
        for (int k = 0; k < NPORT; k++)
            irq_set = irq_set | (change[k] & cfg_r[k].irq_en & ~cfg_r[k].out_en);
    end

    assign irq_clr = hit && (cmd.code == `IOEXP_CMD_LEVELS);

    // a change in the clearing cycle keeps the line up
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            irq_r <= 1'b0;
        else if (irq_set)
            irq_r <= 1'b1;
        else if (irq_clr)
            irq_r <= 1'b0;

endmodule

// ---- bench/ioexp_top_sva.sv ----
`timescale 1ns/1ns
module ioexp_top_sva #(
    parameter int NPORT = 16
) (
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic [3:0]            dev_addr,
    input wire ioexp_pkg::ioexp_cmd_t cmd,
    input wire ioexp_pkg::ioexp_rsp_t rsp_r,
    input wire logic [NPORT-1:0]      pin_in,
    input wire logic [NPORT-1:0]      pin_out_r,
    input wire logic [NPORT-1:0]      pin_oe_r,
    input wire logic                  irq_r
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // **********
    // addressed commands
    // **********
    sequence taken;
        cmd.valid && cmd.addr == dev_addr && dev_addr <= 4'hE;
    endsequence
    sequence took(m);
        taken ##0 cmd.mode_4_1[3:0] == m;
    endsequence
    chk_rsp_taken: assert property (taken |=> rsp_r.valid)
        else $error("addressed command not answered");
    chk_rsp_foreign: assert property (
        !(cmd.valid && cmd.addr == dev_addr && dev_addr <= 4'hE) |=> !rsp_r.valid)
        else $error("answer without addressed command");
    chk_read_ok: assert property (
        taken ##0 cmd.code inside {[7'h01:7'h45], 7'h5B, 7'h5C, 7'h63} |=> rsp_r.ok)
        else $error("read code refused");
    chk_send_zero: assert property (
        taken ##0 cmd.code inside {[7'h46:7'h55], [7'h5D:7'h62]}
        |=> rsp_r.ok && rsp_r.rdata == 32'h0000_0000)
        else $error("send code answer wrong");
    chk_bad_code: assert property (
        taken ##0 !(cmd.code inside {[7'h01:7'h55], [7'h5B:7'h63]}) |=> !rsp_r.ok)
        else $error("undefined code accepted");
    // **********
    // port modes, pins follow two cycles after the command
    // **********
    chk_out_low: assert property (took(4'h1) |-> ##2 pin_oe_r[0] && !pin_out_r[0])
        else $error("mode 1 not driving low");
    chk_out_high: assert property (took(4'h2) |-> ##2 pin_oe_r[0] && pin_out_r[0])
        else $error("mode 2 not driving high");
    chk_in_modes: assert property (
        taken ##0 cmd.mode_4_1[3:0] inside {[4'h3:4'h5]} |-> ##2 !pin_oe_r[0] && !pin_out_r[0])
        else $error("input mode still driving");
    chk_mode_keep: assert property (
        taken ##0 !(cmd.mode_4_1[3:0] inside {[4'h1:4'h5]}) |-> ##2 $stable(pin_oe_r[0]))
        else $error("no-change mode altered port");
    chk_group_top: assert property (
        taken ##0 cmd.mode_16_13[15:12] == 4'h1 |-> ##2 pin_oe_r[NPORT-1] && !pin_out_r[NPORT-1])
        else $error("top group nibble misplaced");
endmodule

// ---- bench/ioexp_host.sv ----
`timescale 1ns/1ns
module ioexp_host (
    input  wire logic                  clk,
    output ioexp_pkg::ioexp_cmd_t      cmd,
    input  wire ioexp_pkg::ioexp_rsp_t rsp_r
);
    int unsigned status_cnt = 0;
    initial cmd = '0;
    // **********
    // one command; answer sampled at the edge after it is taken
    // **********
    task automatic xact(
        input  logic [3:0]  a,
        input  logic [6:0]  c,
        input  logic [15:0] m_hi,
        input  logic [15:0] m_lo,
        output logic        got,
        output logic        ok,
        output logic [31:0] d
    );
        ioexp_pkg::ioexp_cmd_t k;
        k = '0;
        k.valid = 1'b1;
        k.addr = a;
        k.code = c;
        k.mode_16_13 = m_hi;
        k.mode_12_9 = 16'h9999;
        k.mode_8_5 = 16'h9999;
        k.mode_4_1 = m_lo;
        k.wdata = (c inside {[7'h46:7'h55], [7'h5D:7'h62]}) ? 32'hA5A5_0F0F : 32'h0;
        @(posedge clk);
        cmd <= k;
        @(posedge clk);
        // released fields must not keep their last value
        k = ~k;
        k.valid = 1'b0;
        cmd <= k;
        @(posedge clk);
        got = rsp_r.valid;
        ok = rsp_r.ok;
        d = rsp_r.rdata;
        status_cnt = (got === 1'b1 && ok === 1'b1) ? 0 : status_cnt + 1;
    endtask
endmodule

// ---- bench/test_ioexp_top.sv ----
`timescale 1ns/1ns
`define CHK(n, e, a) \
    begin \
        n_tests++; \
        if ((a) !== (e)) \
        begin \
            num_errors++; \
            $display("FAIL %s exp %0h got %0h", n, e, a); \
        end \
    end
module test_ioexp_top;
    logic                  clk;
    logic                  rst_b;
    logic [3:0]            dev_addr;
    logic [15:0]           pin_in;
    ioexp_pkg::ioexp_cmd_t cmd;
    ioexp_pkg::ioexp_rsp_t rsp_r;
    logic [15:0]           pin_out_r;
    logic [15:0]           pin_oe_r;
    logic                  irq_r;
    logic                  got;
    logic                  ok;
    logic [31:0]           d;
    int                    num_errors = 0;
    int                    n_tests = 0;
    int                    cyc = 0;

    ioexp_top #(.NPORT(16), .DEB_CYC(4)) i_dut (.clk, .rst_b, .dev_addr, .cmd, .rsp_r,
        .pin_in, .pin_out_r, .pin_oe_r, .irq_r);
    ioexp_host i_host (.clk, .cmd, .rsp_r);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic go(input logic [6:0] c, input logic [15:0] lo);
        i_host.xact(dev_addr, c, 16'h9999, lo, got, ok, d);
    endtask
    // **********
    // scenarios
    // **********
    task automatic t_modes();
        logic [1:0] exp;
        for (int m = 0; m < 16; m++)
        begin
            go(7'h31, 16'h9992);
            go(7'h31, {12'h999, 4'(m)});
            @(posedge clk);
            exp = (m == 1) ? 2'b10 : (m inside {[3:5]}) ? 2'b00 : 2'b11;
            `CHK("port1 oe,out", exp, {pin_oe_r[0], pin_out_r[0]})
        end
        i_host.xact(dev_addr, 7'h31, 16'h1999, 16'h9999, got, ok, d);
        @(posedge clk);
        `CHK("port16 oe,out", 2'b10, {pin_oe_r[15], pin_out_r[15]})
    endtask
    task automatic t_count();
        go(7'h46, 16'h9994);
        go(7'h31, 16'h9999);
        @(posedge clk);
        `CHK("irq idle", 1'b0, irq_r)
        repeat (3)
        begin
            pin_in[0] <= 1'b1;
            repeat (4) @(posedge clk);
            pin_in[0] <= 1'b0;
            repeat (6) @(posedge clk);
        end
        `CHK("irq on change", 1'b1, irq_r)
        go(7'h01, 16'h9999);
        `CHK("count", 32'h3, d)
        go(7'h11, 16'h9999);
        `CHK("period", 32'hA, d)
        go(7'h21, 16'h9999);
        `CHK("high time", 32'h4, d)
        go(7'h31, 16'h9999);
        `CHK("levels", 32'h0, d)
        go(7'h5D, 16'h9999);
        go(7'h01, 16'h9999);
        `CHK("count kept", 32'h3, d)
        go(7'h46, 16'h9999);
        go(7'h01, 16'h9999);
        `CHK("count cleared", 32'h0, d)
    endtask
    task automatic t_deb();
        go(7'h31, 16'h9959);
        go(7'h31, 16'h9999);
        pin_in[1] <= 1'b1;
        repeat (2) @(posedge clk);
        pin_in[1] <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("glitch irq", 1'b0, irq_r)
        go(7'h31, 16'h9999);
        `CHK("glitch level", 32'h0, d)
        pin_in[1] <= 1'b1;
        repeat (15) @(posedge clk);
        `CHK("debounced irq", 1'b1, irq_r)
        go(7'h31, 16'h9999);
        `CHK("debounced level", 32'h2, d)
    endtask
    task automatic t_addr();
        i_host.xact(4'h3, 7'h01, 16'h9999, 16'h9991, got, ok, d);
        `CHK("foreign answer", 1'b0, got)
        dev_addr <= 4'hF;
        repeat (3) @(posedge clk);
        i_host.xact(4'hF, 7'h01, 16'h9999, 16'h9991, got, ok, d);
        `CHK("addr 15 answer", 1'b0, got)
        @(posedge clk);
        `CHK("port1 kept", 1'b0, pin_oe_r[0])
        `CHK("fail count", 2, i_host.status_cnt)
        dev_addr <= 4'h5;
        repeat (3) @(posedge clk);
        go(7'h01, 16'h9999);
        `CHK("fail count clr", 0, i_host.status_cnt)
    endtask
    task automatic t_codes();
        logic [6:0] cl [12] = '{7'h01, 7'h45, 7'h5B, 7'h5C, 7'h63, 7'h46, 7'h55, 7'h5D,
            7'h62, 7'h56, 7'h5A, 7'h64};
        for (int i = 0; i < 12; i++)
        begin
            go(cl[i], 16'h9999);
            `CHK("answered", 1'b1, got)
            `CHK("ok", (cl[i] inside {[7'h01:7'h55], [7'h5B:7'h63]}), ok)
        end
    endtask
    initial
    begin
        rst_b = 1'b0;
        dev_addr = 4'h5;
        pin_in = 16'h0000;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        t_modes();
        t_count();
        t_deb();
        t_addr();
        t_codes();
        end_sim();
    end
endmodule
bind ioexp_top ioexp_top_sva #(.NPORT(NPORT)) i_sva (.clk, .rst_b, .dev_addr, .cmd, .rsp_r,
    .pin_in, .pin_out_r, .pin_oe_r, .irq_r);
